// ---- rtl/sbrg_top.sv ----
// baud rate generator: source select, divider, oversampling, pin roles
// Contract
// - source: peripheral clock, divided by eight, pin
// - sixteen-bit divider loaded from divisor value
// - divisor zero produces no clock, except sync external clock, where the divisor is forced to one
// - divisor one bypasses the divider
// - async: divided clock samples, then bit divide
// - oversample bit picks eight or sixteen
// - async rate is source over 8(2-over)cd
// - nonzero fraction part enables fractional division
// - fraction resolution is one eighth divisor
// - fraction only in normal serial mode
// - transmit line mosi master, miso slave
// - active low slave select on cts/rts
// - gated clock resumes exact prior state
// - single interrupt request output
// - sync external clock taken undivided
// - sync/spi rate is source over divisor
`timescale 1ns/1ps
module sbrg_top (
  // clock and reset
  input  wire logic           mclk_in,
  input  wire logic           reset_in,
  // configuration
  input  wire logic [1:0]     clock_source_select_in,
  input  wire logic [3:0]     port_mode_in,
  input  wire logic           sync_mode_in,
  input  wire logic           over_in,
  input  wire logic           spi_master_in,
  input  wire sbrg_pkg::sbrg_cd_t divisor_value_in,
  input  wire sbrg_pkg::sbrg_fp_t fraction_part_in,
  input  wire logic           rate_divider_wr_in,
  input  wire logic           irq_event_in,
  input  wire logic           slave_select_req_in,
  // pins
  input  wire logic           sck_pin_in,
  input  wire logic           cts_n_in,
  // serial data from the port
  input  wire logic           tx_data_in,
  input  wire logic           rx_pin_in,
  // outputs
  output logic                sample_tick_out,
  output logic                baud_tick_out,
  output logic                mosi_out,
  output logic                miso_out,
  output logic                rx_data_out,
  output logic                slave_sel_n_out,
  output logic                rts_n_out,
  output logic                irq_out
);
  import sbrg_pkg::*;
  sbrg_div_if dif ();
  sbrg_cd_t cd_r;
  sbrg_fp_t fp_r;
  logic       load_r;
  logic [1:0] sck_sync_r;
  logic       sck_prev_r;
  logic [1:0] rx_sync_r;
  logic [1:0] cts_sync_r;
  logic [2:0] pre_r;
  logic [3:0] bit_cnt_r;
  logic       src_tick;
  logic       ext_edge;
  logic       is_spi;
  logic       ext_direct;
  logic [3:0] bit_last;

  function automatic logic spi_code(input logic [3:0] m);
    spi_code = (m == SBRG_MODE_SPI_MST) || (m == SBRG_MODE_SPI_SLV);
  endfunction

  // state survives a stopped clock because nothing here is self-reset
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      sck_sync_r <= 2'h0;
      sck_prev_r <= 1'b0;
      rx_sync_r  <= 2'h3;
      cts_sync_r <= 2'h3;
    end else begin
      sck_sync_r <= {sck_sync_r[0], sck_pin_in};
      sck_prev_r <= sck_sync_r[1];
      rx_sync_r  <= {rx_sync_r[0], rx_pin_in};
      cts_sync_r <= {cts_sync_r[0], cts_n_in};
    end
  end

  // rising external edge; pin must be slow enough to sample
  assign ext_edge = sck_sync_r[1] && !sck_prev_r;
  assign is_spi   = spi_code(port_mode_in);

  // fixed prescaler for the divided peripheral clock
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      pre_r <= 3'h0;
    end else begin
      pre_r <= pre_r + 3'h1;
    end
  end

  always_comb begin
    case (clock_source_select_in)
      SBRG_CLKS_MCK: src_tick = 1'b1;
      SBRG_CLKS_DIV: src_tick = (pre_r == SBRG_PRE_LAST);
      SBRG_CLKS_EXT: src_tick = ext_edge;
      default:       src_tick = 1'b1;
    endcase
  end

  // divider register write reloads divider
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      cd_r   <= SBRG_CD_RESET;
      fp_r   <= SBRG_FP_RESET;
      load_r <= 1'b0;
    end else begin
      load_r <= rate_divider_wr_in;
      if (rate_divider_wr_in) begin
        cd_r <= divisor_value_in;
        fp_r <= fraction_part_in;
      end
    end
  end

  assign ext_direct = sync_mode_in &&
                      clock_source_select_in == SBRG_CLKS_EXT;
  assign dif.src_tick = src_tick;
  assign dif.load     = load_r;
  assign dif.cd       = ext_direct ? 16'h0001 : cd_r;
  assign dif.fp       = fp_r;
  // fraction only in async normal mode
  assign dif.frac_en  = (fp_r != 3'h0) && !sync_mode_in &&
                        port_mode_in == SBRG_MODE_NORMAL;

  sbrg_div u_div (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .d        (dif)
  );

  assign bit_last = over_in ? SBRG_BIT_LAST8 : SBRG_BIT_LAST16;

  // bit clock from sampling clock, async only
  always_ff @(posedge mclk_in) begin
    if (reset_in || load_r) begin
      bit_cnt_r <= 4'h0;
    end else if (dif.out_tick && !(sync_mode_in || is_spi)) begin
      bit_cnt_r <= (bit_cnt_r >= bit_last) ? 4'h0 : bit_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      sample_tick_out <= 1'b0;
      baud_tick_out   <= 1'b0;
    end else begin
      sample_tick_out <= dif.out_tick;
      if (sync_mode_in || is_spi) begin
        baud_tick_out <= dif.out_tick;
      end else begin
        baud_tick_out <= dif.out_tick && bit_cnt_r >= bit_last;
      end
    end
  end

  // pin roles for spi and handshake
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      mosi_out        <= 1'b1;
      miso_out        <= 1'b1;
      rx_data_out     <= 1'b1;
      slave_sel_n_out <= 1'b1;
      rts_n_out       <= 1'b1;
      irq_out         <= 1'b0;
    end else begin
      mosi_out    <= spi_master_in ? tx_data_in : rx_sync_r[1];
      miso_out    <= spi_master_in ? rx_sync_r[1] : tx_data_in;
      rx_data_out <= rx_sync_r[1];
      slave_sel_n_out <= (is_spi && !spi_master_in) ?
                         cts_sync_r[1] : 1'b1;
      rts_n_out   <= (is_spi && spi_master_in) ?
                     !slave_select_req_in : 1'b1;
      irq_out     <= irq_event_in;
    end
  end

  a_zero_cd_quiet: assert property (@(posedge mclk_in)
    disable iff (reset_in)
    (cd_r == 16'h0000 && !ext_direct && !load_r)[*3] |=> !sample_tick_out)
    else $error("sampling clock with zero divisor");

  a_bypass_pass: assert property (@(posedge mclk_in)
    disable iff (reset_in)
    (cd_r == 16'h0001 && !dif.frac_en && !load_r &&
     clock_source_select_in == SBRG_CLKS_MCK && $stable(cd_r))
    |=> ##1 sample_tick_out)
    else $error("bypass did not pass source clock");

  a_baud_subset: assert property (@(posedge mclk_in)
    disable iff (reset_in)
    baud_tick_out |-> sample_tick_out)
    else $error("baud tick without sample tick");

  a_rts_master: assert property (@(posedge mclk_in)
    disable iff (reset_in)
    (is_spi && spi_master_in && slave_select_req_in &&
     $stable(port_mode_in)) |=> !rts_n_out)
    else $error("master select not driven low");

  a_mosi_role: assert property (@(posedge mclk_in)
    disable iff (reset_in)
    spi_master_in |=> mosi_out == $past(tx_data_in))
    else $error("transmit line not mosi as master");

  // the select may move off the divided source inside the window
  a_div_prescale: assert property (@(posedge mclk_in)
    disable iff (reset_in)
    (clock_source_select_in == SBRG_CLKS_DIV && src_tick)
    |=> (!src_tick || clock_source_select_in != SBRG_CLKS_DIV) [*7])
    else $error("divided source faster than one in eight");

  a_irq_follow: assert property (@(posedge mclk_in)
    disable iff (reset_in)
    irq_event_in |=> irq_out)
    else $error("interrupt request missed");

  a_load_restart: assert property (@(posedge mclk_in)
    disable iff (reset_in)
    load_r |=> bit_cnt_r == 4'h0)
    else $error("bit counter not restarted");
endmodule

// ---- rtl/sbrg_pkg.sv ----
// shared constants and types for the serial baud rate generator
package sbrg_pkg;
  localparam int unsigned SBRG_CD_W       = 16;
  localparam int unsigned SBRG_FP_W       = 3;
  localparam int unsigned SBRG_DIV_FIXED  = 8;
  localparam int unsigned SBRG_OVER16     = 16;
  localparam int unsigned SBRG_OVER8      = 8;
  localparam int unsigned SBRG_FRAC_STEPS = 8;
  localparam logic [3:0]  SBRG_MODE_NORMAL  = 4'h0;
  localparam logic [3:0]  SBRG_MODE_SPI_MST = 4'hE;
  localparam logic [3:0]  SBRG_MODE_SPI_SLV = 4'hF;
  localparam logic [1:0]  SBRG_CLKS_MCK   = 2'h0;
  localparam logic [1:0]  SBRG_CLKS_DIV   = 2'h1;
  localparam logic [1:0]  SBRG_CLKS_EXT   = 2'h3;
  localparam logic [15:0] SBRG_CD_RESET   = 16'h0000;
  localparam logic [2:0]  SBRG_FP_RESET   = 3'h0;
  localparam logic [2:0]  SBRG_PRE_LAST   = 3'h7;
  localparam logic [3:0]  SBRG_BIT_LAST16 = 4'hF;
  localparam logic [3:0]  SBRG_BIT_LAST8  = 4'h7;
  typedef logic [15:0] sbrg_cd_t;
  typedef logic [2:0]  sbrg_fp_t;
endpackage

// ---- rtl/sbrg_div_if.sv ----
// link between the baud top and its fractional divider core
`timescale 1ns/1ps
interface sbrg_div_if;
  import sbrg_pkg::*;
  logic     src_tick;
  logic     load;
  sbrg_cd_t cd;
  sbrg_fp_t fp;
  logic     frac_en;
  logic     out_tick;
  modport ctrl (output src_tick, load, cd, fp, frac_en, input out_tick);
  modport core (input src_tick, load, cd, fp, frac_en, output out_tick);
endinterface

// ---- rtl/sbrg_div.sv ----
// fractional 16-bit divider on source ticks
`timescale 1ns/1ps
module sbrg_div (
  // clock and reset
  input  wire logic   mclk_in,
  input  wire logic   reset_in,
  // divider link
  sbrg_div_if.core    d
);
  import sbrg_pkg::*;
  logic [15:0] cnt_r;
  logic [2:0]  phase_r;
  logic        extra_r;
  logic        tick_r;
  logic        spread;

  // extra period when fp ones spread over eight outputs
  function automatic logic frac_hit(input logic [2:0] ph,
                                    input logic [2:0] fp);
    frac_hit = ({1'b0, ph} * 4'(fp)) % 4'(SBRG_FRAC_STEPS) + 4'(fp)
               >= 4'(SBRG_FRAC_STEPS);
  endfunction

  always_comb spread = d.frac_en && frac_hit(phase_r, d.fp);

  always_ff @(posedge mclk_in) begin
    if (reset_in || d.load) begin
      cnt_r   <= 16'h0001;
      phase_r <= 3'h0;
      extra_r <= 1'b0;
      tick_r  <= 1'b0;
    end else begin
      tick_r <= 1'b0;
      if (d.src_tick && d.cd != 16'h0000) begin
        if (d.cd == 16'h0001 && !d.frac_en) begin
          tick_r <= 1'b1;
        end else if (cnt_r >= d.cd && !(spread && !extra_r)) begin
          tick_r  <= 1'b1;
          cnt_r   <= 16'h0001;
          extra_r <= 1'b0;
          phase_r <= phase_r + 3'h1;
        end else if (cnt_r >= d.cd) begin
          extra_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 16'h0001;
        end
      end
    end
  end

  assign d.out_tick = tick_r;

  a_zero_cd_silent: assert property (@(posedge mclk_in)
    disable iff (reset_in)
    (d.cd == 16'h0000 && !d.load) |=> !tick_r)
    else $error("divider ticked with zero divisor");
endmodule

// ---- dv/sbrg_remote.sv ----
// remote serial device: external serial clock and line levels
`timescale 1ns/1ps
module sbrg_remote #(
  parameter int HALF = 4
) (
  // clock and enables
  input  wire logic clk_in,
  input  wire logic sck_en_in,
  // levels wanted by the bench
  input  wire logic rx_in,
  input  wire logic sel_n_in,
  // pins toward the port
  output logic      sck_out,
  output logic      rx_out,
  output logic      cts_n_out
);
  int cnt = 0;
  initial sck_out = 1'h0;
  // clock stands still low unless enabled; phases of HALF cycles
  always @(posedge clk_in) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (!sck_en_in)
      sck_out <= #1 1'h0;
    else if (cnt == HALF - 1)
      sck_out <= #1 !sck_out;
  end
  assign rx_out    = rx_in;
  assign cts_n_out = sel_n_in;  // low selects the port as slave
endmodule

// ---- dv/tb.sv ----
// self-checking bench for the baud rate generator
`timescale 1ns/1ps
module tb;
  import sbrg_pkg::*;
  localparam int HALF = 4;
  typedef struct { int n; int t; } sbrg_exp_t;
  logic clk = 0, run = 1, rst = 1, wr = 0, sy = 0, ov = 0, sm = 0;
  logic irq = 0, req = 0, tx = 0, rx = 1, cts_n = 1, sen = 0;
  logic [1:0] cs = 0;
  logic [3:0] md = 0;
  sbrg_cd_t   cd = 0;
  sbrg_fp_t   fp = 0;
  logic mclk, sck, rxp, ctsp, stk, btk, mosi, miso, rxd, ssn, rtsn, irqo;
  int   n_errors = 0, tests_run = 0, cyc = 0, gap = 0, acc = 0, k = 0;
  int   sc = 0, nt = 0, sk_s = 0, sk_b = 0, blk = 0, v, c0;
  sbrg_exp_t qs[$];
  int        qb[$];
  initial forever #2.5 clk = !clk;
  assign mclk = clk & run;
  // gated clock stops now and then in mid-count
  initial forever begin
    repeat (701) @(negedge clk);
    #1 run = 0;
    repeat (9) @(negedge clk);
    #1 run = 1;
  end
  sbrg_top u_dut (
    .mclk_in                (mclk),
    .reset_in               (rst),
    .clock_source_select_in (cs),
    .port_mode_in           (md),
    .sync_mode_in           (sy),
    .over_in                (ov),
    .spi_master_in          (sm),
    .divisor_value_in       (cd),
    .fraction_part_in       (fp),
    .rate_divider_wr_in     (wr),
    .irq_event_in           (irq),
    .slave_select_req_in    (req),
    .sck_pin_in             (sck),
    .cts_n_in               (ctsp),
    .tx_data_in             (tx),
    .rx_pin_in              (rxp),
    .sample_tick_out        (stk),
    .baud_tick_out          (btk),
    .mosi_out               (mosi),
    .miso_out               (miso),
    .rx_data_out            (rxd),
    .slave_sel_n_out        (ssn),
    .rts_n_out              (rtsn),
    .irq_out                (irqo)
  );
  sbrg_remote #(.HALF(HALF)) u_far (
    .clk_in    (mclk),
    .sck_en_in (sen),
    .rx_in     (rx),
    .sel_n_in  (cts_n),
    .sck_out   (sck),
    .rx_out    (rxp),
    .cts_n_out (ctsp)
  );
  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    tests_run++;
    if (a !== e) begin
      n_errors++;
      $display("Error t=%0t got=%0h exp=%0h", $time, a, e);
    end
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // monitor: tick spacing against the oldest noted expectation
  always @(posedge mclk) begin
    gap++;
    // ticks of the old setting may show for three edges after a write
    if (wr) begin
      blk = 3;
      sk_s = 1;
      sk_b = 1;
      sc = 0;
      acc = 0;
      k = 0;
    end
    if (stk === 1'h1 && blk == 0) begin
      nt++;
      sc++;
      if (sk_s > 0)
        sk_s--;
      else if (qs.size() > 0) begin
        acc += gap;
        k++;
        if (k == qs[0].n) begin
          chk(acc, qs[0].t);
          void'(qs.pop_front());
          acc = 0;
          k = 0;
        end
      end
      gap = 0;
    end
    if (btk === 1'h1 && blk == 0) begin
      if (sk_b > 0)
        sk_b--;
      else if (qb.size() > 0)
        chk(sc, qb.pop_front());
      sc = 0;
    end
    if (blk > 0)
      blk--;
  end
  task automatic cfg(input logic [1:0] c, input logic [3:0] m,
                     input int s, o, d, f, np, nb);
    int sf, fe, n, t, g;
    sf = (c == 2'h1) ? SBRG_DIV_FIXED : (c == 2'h3) ? 2 * HALF : 1;
    fe = (s == 0 && m == SBRG_MODE_NORMAL) ? f : 0;
    n = (fe != 0) ? SBRG_FRAC_STEPS : 1;
    t = (s != 0 && c == 2'h3) ? sf : sf * (n * d + fe);
    @(posedge mclk);
    #1;
    {cs, md, sy, ov} = {c, m, s[0], o[0]};
    {cd, fp, wr} = {d[15:0], f[2:0], 1'h1};
    @(posedge mclk);
    #1 wr = 0;
    repeat (np) qs.push_back('{n, t});
    repeat (nb) qb.push_back(s ? 1 : (o ? SBRG_OVER8 : SBRG_OVER16));
    for (g = 0; g < 6000 && qs.size() + qb.size() > 0; g++) @(posedge mclk);
    chk(qs.size() + qb.size(), 0);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(38638));
    repeat (10) @(posedge mclk);
    #1;
    chk({irqo, ssn, rtsn, stk}, 4'h6);
    rst = 0;
    cfg(2'h0, 4'h0, 0, 0, 0, 0, 0, 0);
    c0 = nt;
    repeat (200) @(posedge mclk);
    chk(nt - c0, 0);
    cfg(2'h0, 4'h0, 0, 1, 1, 0, 4, 0);
    for (int i = 0; i < 4; i++) begin
      v = 2 + $urandom % 8;
      cfg(2'h0, 4'h0, 0, i % 2, v, 0, 3, 1);
    end
    cfg(2'h1, 4'h0, 0, 1, 3, 0, 2, 1);
    for (int f = 1; f < 8; f++)
      cfg(2'h0, 4'h0, 0, f % 2, 2 + $urandom % 6, f, 2, 0);
    cfg(2'h0, 4'hE, 0, 0, 4, 5, 2, 0);
    cfg(2'h1, 4'h0, 1, 0, 3, 5, 2, 2);
    #1 sen = 1;
    cfg(2'h3, 4'h0, 1, 0, 7, 0, 3, 2);
    cfg(2'h3, 4'h0, 0, 1, 2, 0, 2, 1);
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      @(posedge mclk);
      #1;
      sm = i % 2;
      md = sm ? 4'hE : 4'hF;
      {tx, rx, req, cts_n, irq} = v[4:0];
      repeat (6) @(posedge mclk);
      #1;
      chk(sm ? mosi : miso, tx);
      chk(rxd, rx);
      chk(sm ? miso : mosi, rx);
      chk(rtsn, sm ? !req : 1'h1);
      chk(ssn, sm ? 1'h1 : cts_n);
      chk(irqo, irq);
    end
    wrap_up();
  end
endmodule
